// ===== rtl/hrs_index.sv
// Once-per-revolution index pulse made from the position feedback steps.
// Assumes step and step_dec come from logic on pclk; the pulse stays
// inside the block and is never driven to a pin.
`include "hrs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module hrs_index #(
  parameter int unsigned COUNTS_PER_REV = `HRS_COUNTS_PER_REV
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic step,
  input  wire logic step_dec,
  output logic      z_pulse
);
  localparam int unsigned CW = $clog2(COUNTS_PER_REV);
  localparam logic [CW-1:0] TOP = CW'(COUNTS_PER_REV - 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_z;

  // Angle within one revolution; wrapping either way marks the index
  always_comb begin
    next_cnt = cnt;
    next_z   = 1'b0;
    if (step) begin
      if (step_dec) begin
        next_cnt = (cnt == '0) ? TOP : cnt - 1'b1;
        next_z   = (cnt == '0);
      end else begin
        next_cnt = (cnt == TOP) ? '0 : cnt + 1'b1;
        next_z   = (cnt == TOP);
      end
    end
  end

  // Registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt     <= '0;
      z_pulse <= 1'b0;
    end else if (ce) begin
      cnt     <= next_cnt;
      z_pulse <= next_z;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/hrs_sequencer.sv
// Home return method sequencer: APB register file and homing sequence.
// Assumes pos_step/pos_dec come from the position feedback on pclk;
// dog_pin and servo_on_pin are asynchronous pins.
`include "hrs_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module hrs_sequencer #(
  parameter int unsigned COUNTS_PER_REV = `HRS_COUNTS_PER_REV,
  parameter int unsigned STALL_CYC      =
    `HRS_STALL_TIME_US * `HRS_CLK_MHZ
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              dog_pin,
  input  wire logic              servo_on_pin,
  input  wire logic              pos_step,
  input  wire logic              pos_dec,
  output logic                   motion_en,
  output logic                   motion_dec,
  output logic      [15:0]       speed_cmd,
  output logic                   home_busy,
  output logic                   home_done,
  output hrs_pkg::hrs_state_e    home_state
);
  import hrs_pkg::*;

  // -------------------------------------------------------------
  // Decode
  // -------------------------------------------------------------
  // Used by the error answer and the write path
  function automatic logic hrs_mapped(input logic [7:0] a);
    hrs_mapped = (a == `HRS_OFF_CTRL)  || (a == `HRS_OFF_HSPD)  ||
                 (a == `HRS_OFF_CSPD)  || (a == `HRS_OFF_HPOS)  ||
                 (a == `HRS_OFF_SHIFT) || (a == `HRS_OFF_AFTER) ||
                 (a == `HRS_OFF_STAT)  || (a == `HRS_OFF_CPOS);
  endfunction

  logic        setup_ph;
  logic        wr_acc;
  logic        start_req;
  logic [3:0]  homing_method_select;
  logic        homing_direction_select;
  logic        input_polarity_setting;
  logic [15:0] homing_speed_setting;
  logic [15:0] creep_speed_setting;
  logic [31:0] home_position_value_setting;
  logic [31:0] shift_dist;
  logic [31:0] after_dist;
  logic [3:0]  next_method;
  logic        next_dir;
  logic        next_pol;
  logic [15:0] next_hspd;
  logic [15:0] next_cspd;
  logic [31:0] next_hpos;
  logic [31:0] next_shift;
  logic [31:0] next_after;
  logic [31:0] next_prdata;
  logic [31:0] cur_pos;

  // Zero-wait slave; error only for an unmapped access phase
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~hrs_mapped(paddr);
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite & hrs_mapped(paddr);

  // -------------------------------------------------------------
  // Register file
  // -------------------------------------------------------------
  // Settings lock while a return runs, so a method change cannot
  // tear a sequence in half; read data is captured in setup phase
  always_comb begin
    next_method = homing_method_select;
    next_dir    = homing_direction_select;
    next_pol    = input_polarity_setting;
    next_hspd   = homing_speed_setting;
    next_cspd   = creep_speed_setting;
    next_hpos   = home_position_value_setting;
    next_shift  = shift_dist;
    next_after  = after_dist;
    start_req   = 1'b0;
    next_prdata = prdata;
    if (wr_acc && !home_busy) begin
      case (paddr)
        `HRS_OFF_CTRL: begin
          next_method = pwdata[`HRS_CTRL_METHOD_MSB:`HRS_CTRL_METHOD_LSB];
          next_dir    = pwdata[`HRS_CTRL_DIR_BIT];
          next_pol    = pwdata[`HRS_CTRL_POL_BIT];
          start_req   = pwdata[`HRS_CTRL_START_BIT];
        end
        `HRS_OFF_HSPD:  next_hspd  = pwdata[`HRS_SPD_MSB:0];
        `HRS_OFF_CSPD:  next_cspd  = pwdata[`HRS_SPD_MSB:0];
        `HRS_OFF_HPOS:  next_hpos  = pwdata;
        `HRS_OFF_SHIFT: next_shift = pwdata;
        `HRS_OFF_AFTER: next_after = pwdata;
        default: ;
      endcase
    end
    if (setup_ph && !pwrite) begin
      next_prdata = `HRS_RST_WORD;
      case (paddr)
        `HRS_OFF_CTRL: begin
          next_prdata[`HRS_CTRL_METHOD_MSB:`HRS_CTRL_METHOD_LSB] =
            homing_method_select;
          next_prdata[`HRS_CTRL_DIR_BIT] = homing_direction_select;
          next_prdata[`HRS_CTRL_POL_BIT] = input_polarity_setting;
        end
        `HRS_OFF_HSPD:  next_prdata[`HRS_SPD_MSB:0] = homing_speed_setting;
        `HRS_OFF_CSPD:  next_prdata[`HRS_SPD_MSB:0] = creep_speed_setting;
        `HRS_OFF_HPOS:  next_prdata = home_position_value_setting;
        `HRS_OFF_SHIFT: next_prdata = shift_dist;
        `HRS_OFF_AFTER: next_prdata = after_dist;
        `HRS_OFF_STAT: begin
          next_prdata[`HRS_STAT_BUSY_BIT] = home_busy;
          next_prdata[`HRS_STAT_DONE_BIT] = home_done;
          next_prdata[`HRS_STAT_STATE_MSB:`HRS_STAT_STATE_LSB] = home_state;
        end
        `HRS_OFF_CPOS:  next_prdata = cur_pos;
        default: ;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      homing_method_select        <= `HRS_RST_METHOD;
      homing_direction_select     <= `HRS_RST_BIT;
      input_polarity_setting      <= `HRS_RST_BIT;
      homing_speed_setting        <= `HRS_RST_HSPD;
      creep_speed_setting         <= `HRS_RST_CSPD;
      home_position_value_setting <= `HRS_RST_WORD;
      shift_dist                  <= `HRS_RST_WORD;
      after_dist                  <= `HRS_RST_WORD;
      prdata                      <= `HRS_RST_WORD;
    end else if (ce) begin
      homing_method_select        <= next_method;
      homing_direction_select     <= next_dir;
      input_polarity_setting      <= next_pol;
      homing_speed_setting        <= next_hspd;
      creep_speed_setting         <= next_cspd;
      home_position_value_setting <= next_hpos;
      shift_dist                  <= next_shift;
      after_dist                  <= next_after;
      prdata                      <= next_prdata;
    end
  end

  // -------------------------------------------------------------
  // Inputs
  // -------------------------------------------------------------
  logic        dog_s;
  logic        servo_s;
  logic        z_pulse;
  logic        uses_dog;
  logic        dog_hit;
  logic        dog_q;
  logic        servo_q;
  hrs_method_e meth;
  hrs_method_e start_meth;

  hrs_sync #(.W(2)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .pin      ({dog_pin, servo_on_pin}),
    .pin_sync ({dog_s, servo_s})
  );

  hrs_index #(.COUNTS_PER_REV(COUNTS_PER_REV)) u_index (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .step     (pos_step),
    .step_dec (pos_dec),
    .z_pulse  (z_pulse)
  );

  // Method decode and polarity-corrected dog level
  assign meth     = hrs_method_e'(homing_method_select);
  assign start_meth = hrs_method_e'(next_method);  // Same-write method
  assign uses_dog = !(meth == HRS_M_DATA || meth == HRS_M_STOPPER ||
                      meth == HRS_M_IGNORE || meth == HRS_M_ZONLY);
  assign dog_hit  = uses_dog &
    (input_polarity_setting ? dog_s : ~dog_s);

  // -------------------------------------------------------------
  // Homing sequence
  // -------------------------------------------------------------
  hrs_state_e  next_state;
  logic [31:0] dist_cnt;
  logic [31:0] next_dist;
  logic [31:0] stall_cnt;
  logic [31:0] next_stall;
  logic [31:0] next_cur_pos;
  logic        next_en;
  logic        next_mdec;
  logic [15:0] next_spd;
  logic        next_done;
  logic        finish;

  assign home_busy = (home_state != HRS_IDLE);

  // One state per phase of motion; distance counts use feedback steps
  always_comb begin
    next_state   = home_state;
    next_dist    = dist_cnt;
    next_stall   = `HRS_RST_WORD;
    next_en      = motion_en;
    next_mdec    = motion_dec;
    next_spd     = speed_cmd;
    next_done    = home_done;
    next_cur_pos = cur_pos;
    finish       = 1'b0;
    if (pos_step) begin
      next_cur_pos = pos_dec ? cur_pos - 1'b1 : cur_pos + 1'b1;
    end
    unique case (home_state)
      HRS_IDLE: begin
        if (start_req && start_meth != HRS_M_IGNORE &&
            start_meth <= HRS_M_ZONLY) begin
          next_done = 1'b0;
          next_mdec = next_dir;
          next_en   = 1'b1;
          next_spd  = homing_speed_setting;
          case (start_meth)
            HRS_M_DATA: finish = 1'b1;
            HRS_M_STOPPER: begin
              next_spd   = creep_speed_setting;
              next_state = HRS_STALL;
            end
            HRS_M_ZONLY: begin
              next_spd   = creep_speed_setting;
              next_state = HRS_WAITZ;
            end
            HRS_M_DOG, HRS_M_COUNT, HRS_M_REAR, HRS_M_FRONTCNT,
            HRS_M_CRADLE, HRS_M_FIRSTZ, HRS_M_FRONT:
              next_state = HRS_SEEK;
            default: ;  // Servo-on and unknown codes filtered above
          endcase
        end
        // Home is wherever the axis stands as the servo comes on
        if (meth == HRS_M_IGNORE && servo_s && !servo_q) begin
          finish = 1'b1;
        end
      end
      HRS_SEEK: begin
        if (dog_hit && !dog_q) begin
          next_spd = creep_speed_setting;
          case (meth)
            HRS_M_COUNT: begin
              next_dist  = after_dist;
              next_state = HRS_TRAVEL;
            end
            HRS_M_FRONTCNT: begin
              next_dist  = after_dist + shift_dist;
              next_state = HRS_TRAVEL;
            end
            HRS_M_CRADLE: next_state = HRS_WAITZ;
            HRS_M_FIRSTZ: begin
              next_mdec  = ~motion_dec;
              next_state = HRS_WAITZ;
            end
            HRS_M_FRONT: finish = 1'b1;
            default: next_state = HRS_LEAVE;
          endcase
        end
      end
      HRS_LEAVE: begin
        if (!dog_hit && dog_q) begin
          if (meth == HRS_M_REAR) begin
            next_dist  = after_dist + shift_dist;
            next_state = HRS_TRAVEL;
          end else begin
            next_state = HRS_WAITZ;
          end
        end
      end
      HRS_TRAVEL: begin
        if (dist_cnt == `HRS_RST_WORD) begin
          if (meth == HRS_M_COUNT) begin
            next_state = HRS_WAITZ;
          end else begin
            finish = 1'b1;
          end
        end else if (pos_step) begin
          next_dist = dist_cnt - 1'b1;
        end
      end
      HRS_WAITZ: begin
        if (z_pulse) begin
          if (meth == HRS_M_CRADLE) begin
            finish = 1'b1;
          end else begin
            next_dist  = shift_dist;
            next_state = HRS_SHIFT;
          end
        end
      end
      HRS_SHIFT: begin
        if (dist_cnt == `HRS_RST_WORD) begin
          finish = 1'b1;
        end else if (pos_step) begin
          next_dist = dist_cnt - 1'b1;
        end
      end
      HRS_STALL: begin
        // Pressed against the stopper: no feedback step for a while
        if (pos_step) begin
          next_stall = `HRS_RST_WORD;
        end else if (stall_cnt == 32'(STALL_CYC - 1)) begin
          finish = 1'b1;
        end else begin
          next_stall = stall_cnt + 1'b1;
        end
      end
      default: next_state = HRS_IDLE;
    endcase
    if (finish) begin
      next_state   = HRS_IDLE;
      next_en      = 1'b0;
      next_spd     = `HRS_RST_SPD;
      next_done    = 1'b1;
      next_cur_pos = home_position_value_setting;
    end
  end

  // Sequence flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      home_state <= HRS_IDLE;
      dist_cnt   <= `HRS_RST_WORD;
      stall_cnt  <= `HRS_RST_WORD;
      cur_pos    <= `HRS_RST_WORD;
      motion_en  <= `HRS_RST_BIT;
      motion_dec <= `HRS_RST_BIT;
      speed_cmd  <= `HRS_RST_SPD;
      home_done  <= `HRS_RST_BIT;
      dog_q      <= `HRS_RST_BIT;
      servo_q    <= `HRS_RST_BIT;
    end else if (ce) begin
      home_state <= next_state;
      dist_cnt   <= next_dist;
      stall_cnt  <= next_stall;
      cur_pos    <= next_cur_pos;
      motion_en  <= next_en;
      motion_dec <= next_mdec;
      speed_cmd  <= next_spd;
      home_done  <= next_done;
      dog_q      <= dog_hit;
      servo_q    <= servo_s;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/hrs_sync.sv
// Two-flop synchroniser for pins from outside the pclk domain.
// Assumes a free-running pclk; ce freezes both stages.
`timescale 1ns/1ps
`default_nettype none
module hrs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] pin_sync
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync;

  // First stage feeds only the second stage
  always_comb begin
    next_meta = pin;
    next_sync = meta;
  end

  // Both stages reset to idle level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= '0;
      pin_sync <= '0;
    end else if (ce) begin
      meta     <= next_meta;
      pin_sync <= next_sync;
    end
  end
endmodule
`default_nettype wire

// ===== shared/hrs_consts.svh
// Constants of the home return sequencer: offsets, field positions,
// reset values and timing figures.
// Assumes inclusion by bare name from files that need the numbers.
`ifndef HRS_CONSTS_SVH
`define HRS_CONSTS_SVH

// ---------------------------------------------------------------
// Register byte offsets (one aligned 32-bit word each)
// ---------------------------------------------------------------
`define HRS_OFF_CTRL        8'h00
`define HRS_OFF_HSPD        8'h04
`define HRS_OFF_CSPD        8'h08
`define HRS_OFF_HPOS        8'h0C
`define HRS_OFF_SHIFT       8'h10
`define HRS_OFF_AFTER       8'h14
`define HRS_OFF_STAT        8'h18
`define HRS_OFF_CPOS        8'h1C

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define HRS_CTRL_METHOD_LSB 0
`define HRS_CTRL_METHOD_MSB 3
`define HRS_CTRL_DIR_BIT    4
`define HRS_CTRL_POL_BIT    5
`define HRS_CTRL_START_BIT  8
`define HRS_STAT_BUSY_BIT   0
`define HRS_STAT_DONE_BIT   1
`define HRS_STAT_STATE_LSB  4
`define HRS_STAT_STATE_MSB  6
`define HRS_SPD_MSB         15

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define HRS_RST_METHOD      4'h0
`define HRS_RST_BIT         1'b0
`define HRS_RST_HSPD        16'h0100
`define HRS_RST_CSPD        16'h0010
`define HRS_RST_WORD        32'h0000_0000
`define HRS_RST_SPD         16'h0000

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define HRS_CLK_MHZ         100
`define HRS_STALL_TIME_US   1000
`define HRS_COUNTS_PER_REV  4096

`endif

// ===== shared/hrs_pkg.sv
// Types of the home return sequencer: method codes and sequence states.
// Assumes nothing of its surroundings.
package hrs_pkg;

  // Method select codes
  typedef enum logic [3:0] {
    HRS_M_DOG      = 4'b0000,
    HRS_M_COUNT    = 4'b0001,
    HRS_M_DATA     = 4'b0010,
    HRS_M_STOPPER  = 4'b0011,
    HRS_M_IGNORE   = 4'b0100,
    HRS_M_REAR     = 4'b0101,
    HRS_M_FRONTCNT = 4'b0110,
    HRS_M_CRADLE   = 4'b0111,
    HRS_M_FIRSTZ   = 4'b1000,
    HRS_M_FRONT    = 4'b1001,
    HRS_M_ZONLY    = 4'b1010
  } hrs_method_e;

  // Sequence states
  typedef enum logic [2:0] {
    HRS_IDLE   = 3'b000,
    HRS_SEEK   = 3'b001,
    HRS_LEAVE  = 3'b010,
    HRS_TRAVEL = 3'b011,
    HRS_WAITZ  = 3'b100,
    HRS_SHIFT  = 3'b101,
    HRS_STALL  = 3'b110
  } hrs_state_e;

endpackage

// ===== tb/home_return_method_sequencer_test.sv
// Testbench of the home return sequencer: registers and every method.
// Assumes the far end model and the checker are compiled alongside.
`include "hrs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module home_return_method_sequencer_test;
  import hrs_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        servo_on_pin, dog_pin, pos_step, pos_dec, motion_en;
  logic        motion_dec, home_busy, home_done, stall, pol, rewind;
  logic [15:0] speed_cmd;
  hrs_state_e  home_state;
  int          rel, fails, total_checks;

  hrs_sequencer #(.COUNTS_PER_REV(8), .STALL_CYC(20)) dut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dog_pin(dog_pin), .servo_on_pin(servo_on_pin), .pos_step(pos_step),
    .pos_dec(pos_dec), .motion_en(motion_en), .motion_dec(motion_dec),
    .speed_cmd(speed_cmd), .home_busy(home_busy), .home_done(home_done),
    .home_state(home_state)
  );
  hrs_far_end far (
    .pclk(pclk), .presetn(presetn), .motion_en(motion_en),
    .motion_dec(motion_dec), .stall(stall), .pol(pol), .rewind(rewind),
    .pos_step(pos_step), .pos_dec(pos_dec), .dog_pin(dog_pin), .rel(rel)
  );

  // Free running 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk_w(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_b(input string n, input logic e, g);
    chk_w(n, {31'h0, e}, {31'h0, g});
  endtask

  // One APB transfer; waits for pready, takes data at that same edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fails++;
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // One homing run, then completion, speeds, stop point and position
  task automatic home(input logic [3:0] m, input logic dir, p);
    logic [31:0] q;
    logic        e;
    int          n, bad, mag, lo;
    pol    <= p;
    stall  <= (m == 4'h3);
    rewind <= 1'b1;
    apb(1'b1, `HRS_OFF_HPOS, 32'h0000_1200 + m, q, e);
    rewind <= 1'b0;
    apb(1'b1, `HRS_OFF_CTRL, {23'h0, m != 4'h4, 2'b00, p, dir, m}, q, e);
    if (m == 4'h4) servo_on_pin <= 1'b1;
    @(negedge pclk);
    if (m inside {0, 1, 5, 6, 7, 8, 9}) begin
      chk_b("moving", 1'b1, motion_en); // Motion starts
      chk_w("speed", 32'h0000_0200, {16'h0, speed_cmd}); // Fast
      chk_b("direction", dir, motion_dec); // Start side
    end
    if (m == 4'h7) apb(1'b1, `HRS_OFF_CSPD, 32'h0000_0099, q, e);
    n = 0;
    bad = 0;
    while (home_done !== 1'b1 && n < 3000) begin
      @(negedge pclk);
      n++;
      if (home_state inside {HRS_LEAVE, HRS_TRAVEL, HRS_WAITZ, HRS_SHIFT}
          && speed_cmd !== 16'h0040) bad++;
      if (m == 4'h8 && home_state == HRS_WAITZ && motion_dec !== !dir)
        bad++;
    end
    mag = rel < 0 ? -rel : rel;
    chk_w("creep", 32'h0, 32'(bad)); // Slow after switch
    chk_b("done", 1'b1, home_done);
    chk_b("busy", 1'b0, home_busy); // Unknown code stays idle
    lo = m == 4'h9 ? 20 : (m == 4'h6 ? 25 : 46);
    if (m inside {5, 6, 9})
      chk_b("stop", 1'b1, mag >= lo && mag <= lo + 4);
    apb(1'b0, `HRS_OFF_CPOS, 32'h0, q, e);
    chk_w("position", m > 10 ? 32'h0000_120A : 32'h0000_1200 + m, q);
  endtask

  task automatic complete_run();
    $display("checks %0d wrong %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard, far beyond the several hundred cycles the tests take
  initial begin
    #200_000;
    fails++;
    complete_run();
  end

  initial begin
    logic [31:0] q;
    logic        e;
    logic [31:0] rst_val [8] = '{32'h0, 32'h0000_0100, 32'h0000_0010,
                                 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [3:0]  order [13] = '{4, 0, 1, 2, 3, 5, 6, 7, 8, 9, 9, 10, 11};
    fails = 0;
    total_checks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, servo_on_pin, stall, pol, rewind} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0, q, e);
      chk_w("reset value", rst_val[i], q);
    end
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk_b("unmapped error", 1'b1, e);
    chk_w("unmapped read", 32'h0, q);
    apb(1'b1, `HRS_OFF_STAT, 32'hFFFF_FFFF, q, e);
    apb(1'b0, `HRS_OFF_STAT, 32'h0, q, e);
    chk_w("status read only", 32'h0, q);
    apb(1'b1, `HRS_OFF_HSPD, 32'h0000_0200, q, e);
    apb(1'b1, `HRS_OFF_CSPD, 32'h0000_0040, q, e);
    apb(1'b1, `HRS_OFF_SHIFT, 32'h0000_0002, q, e);
    apb(1'b1, `HRS_OFF_AFTER, 32'h0000_0003, q, e);
    for (int i = 0; i < 13; i++) begin
      home(order[i], 1'(i), 1'(i >> 1)); // Codes and settings
    end
    complete_run();
  end
endmodule
`default_nettype wire

// ===== tb/hrs_far_end.sv
// Far side model: axis position feedback and the proximity switch.
// Assumes the sequencer motion outputs on pclk; rewind sets the origin.
`timescale 1ns/1ps
`default_nettype none
module hrs_far_end #(
  parameter int DOG_NEAR = 20, // Switch start distance in counts, scaled down with the run
  parameter int DOG_FAR  = 40
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic motion_en,
  input  wire logic motion_dec,
  input  wire logic stall,
  input  wire logic pol,
  input  wire logic rewind,
  output logic      pos_step,
  output logic      pos_dec,
  output logic      dog_pin,
  output int        rel
);
  logic phase;
  int   mag;

  // One count every second cycle while moving; a stall stops the axis
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 1'b0;
      rel   <= 0;
    end else begin
      phase <= motion_en && !stall && !phase;
      if (rewind) begin
        rel <= 0;
      end else if (pos_step) begin
        rel <= pos_dec ? rel - 1 : rel + 1;
      end
    end
  end

  // Steps follow the enable at once, so no count lands after the stop
  assign pos_step = motion_en && !stall && phase;
  assign pos_dec  = motion_dec;

  // Switch sits at the same distance either way; polarity sets its level
  assign mag     = rel < 0 ? -rel : rel;
  assign dog_pin = (mag >= DOG_NEAR && mag <= DOG_FAR) ? pol : !pol;
endmodule
`default_nettype wire

// ===== tb/hrs_props.sv
// Checker for the home return sequencer, bound to its top module.
// Assumes ce held high and hrs_pkg compiled first.
`timescale 1ns/1ps
`default_nettype none
module hrs_props
  import hrs_pkg::*;
#(
  parameter int unsigned COUNTS_PER_REV = 8,
  parameter int unsigned STALL_CYC      = 20
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                ce,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic                motion_en,
  input wire logic                motion_dec,
  input wire logic [15:0]         speed_cmd,
  input wire logic                home_busy,
  input wire logic                home_done,
  input wire hrs_pkg::hrs_state_e home_state
);
  logic start_req;
  logic start_wr;
  logic start_q;
  logic next_start_q;

  // Start bit written to control; only an idle sequencer may take it
  assign start_req = ce && psel && penable && pwrite && paddr == 8'h00
                     && pwdata[8];
  assign start_wr  = start_req && !home_busy;

  // Keep a start for one cycle, the only cause of a falling done flag
  always_comb begin
    next_start_q = start_req;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
    end else begin
      start_q <= next_start_q;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  pready_high_a: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  slverr_access_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  busy_state_a: assert property (home_busy == (home_state != HRS_IDLE))
    else $error("busy flag disagrees with state");
  seek_start_a: assert property (start_wr && pwdata[3:0] inside
    {4'h0, 4'h1, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9} |=> home_state == HRS_SEEK
    && motion_en && motion_dec == $past(pwdata[4]))
    else $error("start did not begin the search");
  data_set_a: assert property (start_wr && pwdata[3:0] == 4'h2
    |=> home_done && !home_busy)
    else $error("data setting did not complete at once");
  bad_code_a: assert property (start_wr && pwdata[3:0] > 4'hA
    |=> !home_busy [*3])
    else $error("unknown method code started a run");
  motion_end_a: assert property ($fell(motion_en)
    |-> home_done && speed_cmd == 16'h0000)
    else $error("motion stopped without completion");
  idle_quiet_a: assert property (!home_busy
    |-> !motion_en && speed_cmd == 16'h0000)
    else $error("motion while idle");
  done_cause_a: assert property ($fell(home_done) |-> start_q)
    else $error("done cleared without a start");
  done_hold_a: assert property (home_done && !start_req |=> home_done)
    else $error("done flag dropped");
endmodule

bind hrs_sequencer hrs_props #(
  .COUNTS_PER_REV(COUNTS_PER_REV), .STALL_CYC(STALL_CYC)
) u_props (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .motion_en(motion_en),
  .motion_dec(motion_dec), .speed_cmd(speed_cmd),
  .home_busy(home_busy), .home_done(home_done), .home_state(home_state)
);
`default_nettype wire
